// ==== src/alft_pkg.sv ====
// alft_pkg: constants, types and baud table for the adapter link flow and timeout block
// assumes a 200 MHz ref_clk and link/network frames already decoded into one-cycle events
// Operation
// - never issue a second request before the first one's response arrives.
// - drop incoming requests while our own response is still owed.
// - composite get without appliance-fetch property is answered locally.
// - composite get with appliance-fetch property queries appliance first, then answers.
// - composite set without appliance-push property is answered locally.
// - composite set with appliance-push property forwards to appliance, then answers.
// - link responses are due within 3 seconds of the request.
// - initialization processing must finish within 5 seconds.
// - waiting for peer initialization expires after 6 seconds.
// - network node requests must be answered within 5 seconds.
// - adapter waits at most 5 seconds for a confirmation response.
// - reset line low stops the adapter; a rising edge starts reset.
// - link bit rate is one of seven fixed rates, 2400 to 115200.
// - an error frame in reply means failure; resend as after timeout.
package alft_pkg;

  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned TMR_W      = 32;

  localparam int unsigned LINK_RESPONSE_LIMIT_MS           = 3000;
  localparam int unsigned LINK_RESPONSE_LIMIT_ALT_MS       = 3000;
  localparam int unsigned INIT_PROCESS_LIMIT_MS            = 5000;
  localparam int unsigned INIT_WAIT_LIMIT_MS               = 6000;
  localparam int unsigned NODE_RESPONSE_LIMIT_MS           = 5000;
  localparam int unsigned APPLIANCE_CONFIRM_PROCESS_LIMIT_MS = 3000;
  localparam int unsigned DATA_DISPOSAL_WAIT_LIMIT_MS      = 6000;
  localparam int unsigned CONFIRM_ISSUE_LIMIT_MS           = 3000;
  localparam int unsigned ADAPTER_CONFIRM_WAIT_LIMIT_MS    = 5000;

  localparam logic [TMR_W-1:0] LINK_RESPONSE_LIMIT_CYC     = TMR_W'(LINK_RESPONSE_LIMIT_MS * CYC_PER_MS);
  localparam logic [TMR_W-1:0] LINK_RESPONSE_LIMIT_ALT_CYC = TMR_W'(LINK_RESPONSE_LIMIT_ALT_MS * CYC_PER_MS);
  localparam logic [TMR_W-1:0] INIT_PROCESS_LIMIT_CYC      = TMR_W'(INIT_PROCESS_LIMIT_MS * CYC_PER_MS);
  localparam logic [TMR_W-1:0] INIT_WAIT_LIMIT_CYC         = TMR_W'(INIT_WAIT_LIMIT_MS * CYC_PER_MS);
  localparam logic [TMR_W-1:0] NODE_RESPONSE_LIMIT_CYC     = TMR_W'(NODE_RESPONSE_LIMIT_MS * CYC_PER_MS);
  localparam logic [TMR_W-1:0] ADAPTER_CONFIRM_WAIT_LIMIT_CYC = TMR_W'(ADAPTER_CONFIRM_WAIT_LIMIT_MS * CYC_PER_MS);

  // timer slots
  localparam int NUM_TMR  = 6;
  localparam int TI_LINK  = 0;
  localparam int TI_CONF  = 1;
  localparam int TI_APP   = 2;
  localparam int TI_NODE  = 3;
  localparam int TI_IPROC = 4;
  localparam int TI_IWAIT = 5;

  localparam int unsigned NUM_BAUD = 7;
  localparam int unsigned BAUD_BPS [NUM_BAUD] = '{2400, 9600, 19200, 28800, 38400, 57600, 115200};

  // rounded clocks per bit; unlisted selects fall back to the slowest rate
  function automatic logic [TMR_W-1:0] alft_baud_div(input logic [2:0] sel);
    int unsigned rate;
    rate = (32'(sel) < NUM_BAUD) ? BAUD_BPS[sel] : BAUD_BPS[0];
    return TMR_W'((CLK_HZ + rate / 2) / rate);
  endfunction

  localparam logic [2:0]       BAUD_SEL_RST   = 3'h1;
  localparam logic [TMR_W-1:0] BAUD_DIV_RST   = alft_baud_div(BAUD_SEL_RST);
  localparam logic [TMR_W-1:0] BAUD_DIV_2400  = alft_baud_div(3'h0);
  localparam logic [7:0]       RESEND_CNT_RST = 8'h00;
  localparam logic [7:0]       RESEND_CNT_MAX = 8'hFF;

  typedef enum logic [2:0]
  {
    ST_STOP  = 3'b000,
    ST_INIT  = 3'b001,
    ST_IDLE  = 3'b010,
    ST_SEND  = 3'b011,
    ST_WAIT  = 3'b100,
    ST_REPLY = 3'b101
  } alft_state_t;

  typedef struct packed
  {
    logic req;
    logic rsp;
    logic err;
  } alft_link_rx_t;

  typedef struct packed
  {
    logic valid;
    logic is_get;
    logic is_set;
    logic appliance_svc;
  } alft_net_req_t;

  typedef struct packed
  {
    logic send;
    logic confirm;
    logic resend;
  } alft_tx_cmd_t;

  localparam alft_tx_cmd_t TX_CMD_IDLE = '0;

endpackage

// ==== src/alft_timer.sv ====
// alft_timer: one response/limit timer, expiry pulse after LIMIT enabled edges
// assumes start is a single-cycle event from the controller; clear stays high for as long as the reset line is low
module alft_timer
  import alft_pkg::*;
#(
  parameter int unsigned       W     = TMR_W,
  parameter logic [W-1:0]      LIMIT = LINK_RESPONSE_LIMIT_CYC
)
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic start,
  input  wire logic clear,
  output logic      run_ff,
  output logic      expire_ff
);

  logic [W-1:0] cnt_ff;

  // start wins over clear so a fresh request is never lost
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cnt_ff    <= '0;
      run_ff    <= 1'b0;
      expire_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      expire_ff <= 1'b0;
      if (start)
      begin
        run_ff <= 1'b1;
        cnt_ff <= '0;
      end
      else if (clear)
        run_ff <= 1'b0;
      else if (run_ff)
      begin
        if (cnt_ff == LIMIT - 1'b1)
        begin
          run_ff    <= 1'b0;
          expire_ff <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_TMR_LIMIT: assert property ($rose(expire_ff) |-> $past(run_ff) && $past(cnt_ff) == LIMIT - 1'b1)
    else $error("timer expired at wrong count");

  AST_TMR_CLEAR: assert property (clk_en && clear && !start |=> !run_ff && !expire_ff)
    else $error("timer kept running after clear");

endmodule

// ==== src/alft_link_ctrl.sv ====
// alft_link_ctrl: adapter-side transaction control for the appliance serial link
// assumes a framer gives one-cycle frame events and consumes tx_cmd_ff pulses
module alft_link_ctrl
  import alft_pkg::*;
#(
  parameter logic [TMR_W-1:0] P_LINK_RSP_CYC     = LINK_RESPONSE_LIMIT_CYC,
  parameter logic [TMR_W-1:0] P_CONFIRM_WAIT_CYC = ADAPTER_CONFIRM_WAIT_LIMIT_CYC,
  parameter logic [TMR_W-1:0] P_APP_RSP_CYC      = LINK_RESPONSE_LIMIT_ALT_CYC,
  parameter logic [TMR_W-1:0] P_NODE_RSP_CYC     = NODE_RESPONSE_LIMIT_CYC,
  parameter logic [TMR_W-1:0] P_INIT_PROC_CYC    = INIT_PROCESS_LIMIT_CYC,
  parameter logic [TMR_W-1:0] P_INIT_WAIT_CYC    = INIT_WAIT_LIMIT_CYC
)
(
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  input  wire logic          app_rst_line,
  input  wire logic [2:0]    baud_sel,
  input  wire logic          init_done,
  input  wire logic          peer_init_done,
  input  wire alft_link_rx_t link_rx,
  input  wire logic          link_tx_end,
  input  wire logic          link_rsp_sent,
  input  wire alft_net_req_t net_req,
  input  wire logic          confirm_enq,
  output logic               stopped_ff,
  output logic               reset_start_ff,
  output logic [TMR_W-1:0]   baud_div_ff,
  output alft_tx_cmd_t       tx_cmd_ff,
  output logic               rx_req_take_ff,
  output logic               rx_req_drop_ff,
  output logic               rsp_pending_ff,
  output logic               net_rsp_ff,
  output logic               net_req_drop_ff,
  output logic [NUM_TMR-1:0] tmo_ff,
  output logic [7:0]         resend_cnt_ff
);

  localparam logic [NUM_TMR-1:0][TMR_W-1:0] TMR_LIM =
    {P_INIT_WAIT_CYC, P_INIT_PROC_CYC, P_NODE_RSP_CYC, P_APP_RSP_CYC, P_CONFIRM_WAIT_CYC, P_LINK_RSP_CYC};

  alft_state_t        state_ff;
  alft_state_t        nxt_state;
  logic               rst_d_ff;
  logic               net_pend_ff;
  logic               cmd_conf_ff;
  logic               init_ok_ff;
  logic               peer_ok_ff;
  logic               rst_rise;
  logic               net_take;
  logic               net_fwd;
  logic               conf_take;
  logic               new_cmd;
  logic               rsp_ok;
  logic               retry;
  logic               init_fin;
  logic               init_retry;
  logic               req_take;
  logic [NUM_TMR-1:0] tmr_start;
  logic [NUM_TMR-1:0] tmr_clear;
  logic [NUM_TMR-1:0] tmr_run;
  logic [NUM_TMR-1:0] tmr_exp;

  ////////////////////////////////////////////////////////////////////////////////
  // event decode

  always_comb
  begin
    rst_rise   = app_rst_line && !rst_d_ff;
    net_take   = (state_ff == ST_IDLE) && net_req.valid;
    net_fwd    = net_take && (net_req.is_get || net_req.is_set) && net_req.appliance_svc;
    conf_take  = (state_ff == ST_IDLE) && !net_req.valid && confirm_enq;
    new_cmd    = net_fwd || conf_take;
    rsp_ok     = (state_ff == ST_WAIT) && link_rx.rsp;
    retry      = (state_ff == ST_WAIT) && !link_rx.rsp && (link_rx.err || tmr_exp[TI_LINK] || tmr_exp[TI_CONF]);
    init_fin   = (state_ff == ST_INIT) && (init_ok_ff || init_done) && (peer_ok_ff || peer_init_done);
    init_retry = (state_ff == ST_INIT) && !init_fin && (tmr_exp[TI_IPROC] || tmr_exp[TI_IWAIT]);
    req_take   = link_rx.req && !rsp_pending_ff && (state_ff != ST_STOP) && app_rst_line;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence

  always_comb
  begin
    nxt_state = state_ff;
    if (!app_rst_line)
      nxt_state = ST_STOP;
    else
    begin
      case (state_ff)
        ST_STOP:
          if (rst_rise)
            nxt_state = ST_INIT;
        ST_INIT:
          if (init_fin)
            nxt_state = ST_IDLE;
        ST_IDLE:
          if (new_cmd)
            nxt_state = ST_SEND;
          else if (net_take)
            nxt_state = ST_REPLY;
        ST_SEND:
          if (link_tx_end)
            nxt_state = ST_WAIT;
        ST_WAIT:
          if (rsp_ok)
            nxt_state = net_pend_ff ? ST_REPLY : ST_IDLE;
          else if (retry)
            nxt_state = ST_SEND;
        ST_REPLY:
          nxt_state = ST_IDLE;
        default:
          nxt_state = ST_STOP;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      state_ff <= ST_STOP;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rst_d_ff <= 1'b0;
    else if (clk_en)
      rst_d_ff <= app_rst_line;
  end

  // init completion may arrive before the peer's, so both are latched
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      init_ok_ff <= 1'b0;
      peer_ok_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_ff != ST_INIT || init_fin)
      begin
        init_ok_ff <= 1'b0;
        peer_ok_ff <= 1'b0;
      end
      else
      begin
        init_ok_ff <= init_ok_ff || init_done;
        peer_ok_ff <= peer_ok_ff || peer_init_done;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      net_pend_ff <= 1'b0;
      cmd_conf_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (new_cmd)
      begin
        net_pend_ff <= net_fwd;
        cmd_conf_ff <= conf_take;
      end
      else if (state_ff == ST_REPLY || !app_rst_line)
        net_pend_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timers

  always_comb
  begin
    tmr_start = '0;
    tmr_clear = {NUM_TMR{!app_rst_line}};
    tmr_start[TI_LINK] = (state_ff == ST_SEND) && link_tx_end && !cmd_conf_ff;
    tmr_start[TI_CONF] = (state_ff == ST_SEND) && link_tx_end && cmd_conf_ff;
    tmr_start[TI_APP]  = req_take;
    tmr_start[TI_NODE] = net_take;
    tmr_start[TI_IPROC] = rst_rise || init_retry;
    tmr_start[TI_IWAIT] = rst_rise || init_retry;
    tmr_clear[TI_LINK]  = tmr_clear[TI_LINK] || ((state_ff == ST_WAIT) && (link_rx.rsp || link_rx.err));
    tmr_clear[TI_CONF]  = tmr_clear[TI_CONF] || ((state_ff == ST_WAIT) && (link_rx.rsp || link_rx.err));
    tmr_clear[TI_APP]   = tmr_clear[TI_APP] || link_rsp_sent;
    tmr_clear[TI_NODE]  = tmr_clear[TI_NODE] || (state_ff == ST_REPLY);
    tmr_clear[TI_IPROC] = tmr_clear[TI_IPROC] || init_fin;
    tmr_clear[TI_IWAIT] = tmr_clear[TI_IWAIT] || init_fin;
  end

  for (genvar gi = 0; gi < NUM_TMR; gi++)
  begin : g_tmr
    alft_timer #(
      .W     (TMR_W),
      .LIMIT (TMR_LIM[gi])
    ) u_tmr (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .start     (tmr_start[gi]),
      .clear     (tmr_clear[gi]),
      .run_ff    (tmr_run[gi]),
      .expire_ff (tmr_exp[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      stopped_ff     <= 1'b1;
      reset_start_ff <= 1'b0;
      tmo_ff         <= '0;
    end
    else if (clk_en)
    begin
      stopped_ff     <= (nxt_state == ST_STOP);
      reset_start_ff <= rst_rise;
      tmo_ff         <= tmr_exp;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      baud_div_ff <= BAUD_DIV_RST;
    else if (clk_en)
      baud_div_ff <= alft_baud_div(baud_sel);
  end

  // retries are unbounded here; software sees the count and decides to give up
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      tx_cmd_ff     <= TX_CMD_IDLE;
      resend_cnt_ff <= RESEND_CNT_RST;
    end
    else if (clk_en)
    begin
      tx_cmd_ff.send    <= new_cmd || retry;
      tx_cmd_ff.confirm <= retry ? cmd_conf_ff : conf_take;
      tx_cmd_ff.resend  <= retry;
      if (new_cmd)
        resend_cnt_ff <= RESEND_CNT_RST;
      else if (retry && resend_cnt_ff != RESEND_CNT_MAX)
        resend_cnt_ff <= resend_cnt_ff + 8'h01;
    end
  end

  // set wins: a request taken in the cycle of a stray done stays owed
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rsp_pending_ff <= 1'b0;
      rx_req_take_ff <= 1'b0;
      rx_req_drop_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_req_take_ff <= req_take;
      rx_req_drop_ff <= link_rx.req && !req_take;
      if (!app_rst_line)
        rsp_pending_ff <= 1'b0;
      else if (req_take)
        rsp_pending_ff <= 1'b1;
      else if (link_rsp_sent)
        rsp_pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      net_rsp_ff      <= 1'b0;
      net_req_drop_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      net_rsp_ff      <= (state_ff == ST_REPLY);
      net_req_drop_ff <= net_req.valid && (state_ff != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_net_accept;
    clk_en && state_ff == ST_IDLE && net_req.valid;
  endsequence

  sequence s_err_reply;
    clk_en && state_ff == ST_WAIT && !link_rx.rsp && link_rx.err;
  endsequence

  AST_ONE_OUTSTANDING: assert property (clk_en && state_ff == ST_WAIT |=> !(tx_cmd_ff.send && !tx_cmd_ff.resend))
    else $error("new request issued while waiting for response");

  AST_DROP_EXTRA: assert property (clk_en && link_rx.req && rsp_pending_ff |=> rx_req_drop_ff && !rx_req_take_ff)
    else $error("extra request not dropped");

  AST_GET_LOCAL: assert property (s_net_accept ##0 (net_req.is_get && !net_req.appliance_svc)
    |=> state_ff == ST_REPLY ##0 !tx_cmd_ff.send)
    else $error("local get queried appliance");

  AST_GET_FETCH: assert property (s_net_accept ##0 (net_req.is_get && net_req.appliance_svc)
    |=> tx_cmd_ff.send && state_ff == ST_SEND)
    else $error("fetch get did not query appliance");

  AST_SET_LOCAL: assert property (s_net_accept ##0 (net_req.is_set && !net_req.is_get && !net_req.appliance_svc)
    |=> state_ff == ST_REPLY && !tx_cmd_ff.send)
    else $error("local set forwarded to appliance");

  AST_SET_PUSH: assert property (s_net_accept ##0 (net_req.is_set && net_req.appliance_svc)
    |=> tx_cmd_ff.send && !tx_cmd_ff.confirm)
    else $error("push set not forwarded");

  AST_NO_EARLY_REPLY: assert property (clk_en && state_ff == ST_WAIT && net_pend_ff && !link_rx.rsp
    |=> state_ff != ST_REPLY)
    else $error("network reply before appliance response");

  AST_ERR_RESEND: assert property (s_err_reply |=> tx_cmd_ff.send && tx_cmd_ff.resend && state_ff == ST_SEND)
    else $error("error frame did not cause resend");

  AST_TMR_ARM: assert property (clk_en && state_ff == ST_SEND && link_tx_end && !cmd_conf_ff
    |=> tmr_run[TI_LINK])
    else $error("link timer not armed at request end");

  AST_STOP_LOW: assert property (clk_en && !app_rst_line |=> stopped_ff && state_ff == ST_STOP)
    else $error("not stopped while reset line low");

  AST_RST_START: assert property (clk_en && state_ff == ST_STOP && app_rst_line
    |=> reset_start_ff && state_ff == ST_INIT)
    else $error("rising reset line did not start init");

  AST_BAUD_SLOW: assert property (clk_en && baud_sel == 3'h0 |=> baud_div_ff == BAUD_DIV_2400)
    else $error("wrong divider for slowest rate");

endmodule

// ==== test/alft_appliance_model.sv ====
// alft_appliance_model: far end of the serial link, frames seen as one-cycle events
// assumes tx_cmd pulses from alft_link_ctrl; mode 0 answers, 1 error frame once, 2 silent
module alft_appliance_model
  import alft_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire alft_tx_cmd_t tx_cmd,
  input  wire logic [1:0]   mode,
  input  wire logic [7:0]   rsp_dly,
  output logic              tx_end,
  output logic              rsp,
  output logic              err
);
  timeunit 1ns;
  timeprecision 1ps;

  int   tx_cnt   = 0;
  int   rsp_cnt  = 0;
  logic err_done = 1'b0;

  initial
  begin
    tx_end = 1'b0;
    rsp    = 1'b0;
    err    = 1'b0;
  end

  always @(posedge ref_clk)
  begin
    logic fire;
    fire = 1'b0;
    tx_end <= 1'b0;
    rsp    <= 1'b0;
    err    <= 1'b0;
    if (!rst_b)
    begin
      tx_cnt  = 0;
      rsp_cnt = 0;
    end
    else if (tx_cmd.send)
      tx_cnt = 3;
    else if (tx_cnt == 1)
    begin
      tx_cnt  = 0;
      tx_end <= 1'b1;
      rsp_cnt = rsp_dly;
    end
    else if (tx_cnt > 1)
      tx_cnt--;
    else if (rsp_cnt == 1)
    begin
      rsp_cnt = 0;
      fire    = 1'b1;
      rsp    <= (mode == 2'h0) || (mode == 2'h1 && err_done);
      err    <= (mode == 2'h1) && !err_done;
    end
    else if (rsp_cnt > 1)
      rsp_cnt--;
    // no disposal wait modelled
    // error sent once per mode 1 session, so the resend is answered
    err_done <= (mode == 2'h1) && (err_done || fire);
  end
endmodule

// ==== test/test_adapter_link_flow_timeout.sv ====
// test_adapter_link_flow_timeout: self-checking bench for alft_link_ctrl
// assumes alft_appliance_model on the link side and shortened timer parameters
module test_adapter_link_flow_timeout
  import alft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] LNK = 32'h28;
  localparam logic [31:0] CNF = 32'h3C;
  localparam logic [31:0] APP = 32'h1E;
  localparam logic [31:0] NOD = 32'h64;
  localparam logic [31:0] IPR = 32'h3C;
  localparam logic [31:0] IWT = 32'h28;

  logic               ref_clk        = 1'b0;
  logic               rst_b          = 1'b0;
  logic               app_rst_line   = 1'b0;
  logic [2:0]         baud_sel       = 3'h1;
  logic               init_done      = 1'b0;
  logic               peer_init_done = 1'b0;
  logic               lreq           = 1'b0;
  logic               link_rsp_sent  = 1'b0;
  logic               confirm_enq    = 1'b0;
  alft_net_req_t      net_req        = '0;
  logic [1:0]         mode           = 2'h0;
  logic [7:0]         rsp_dly        = 8'h04;
  logic               link_tx_end;
  logic               m_rsp;
  logic               m_err;
  alft_link_rx_t      link_rx;
  logic               stopped_ff;
  logic               reset_start_ff;
  logic [TMR_W-1:0]   baud_div_ff;
  alft_tx_cmd_t       tx_cmd_ff;
  logic               rx_req_take_ff;
  logic               rx_req_drop_ff;
  logic               rsp_pending_ff;
  logic               net_rsp_ff;
  logic               net_req_drop_ff;
  logic [NUM_TMR-1:0] tmo_ff;
  logic [7:0]         resend_cnt_ff;
  logic [13:0]        obs;
  int                 err_count   = 0;
  int                 check_count = 0;
  int                 cnt [14]    = '{default: 0};
  int                 n;
  int                 k;
  int                 rates [7]   = '{2400, 9600, 19200, 28800, 38400, 57600, 115200};

  assign link_rx = '{req: lreq, rsp: m_rsp, err: m_err};
  assign obs = {tmo_ff, m_rsp, rx_req_drop_ff, rx_req_take_ff, net_req_drop_ff, net_rsp_ff,
                tx_cmd_ff.resend, tx_cmd_ff.send, reset_start_ff};

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // pulses last a whole cycle, so the falling edge sees them settled
  always @(negedge ref_clk)
  begin
    for (int i = 0; i < 14; i++)
      if (obs[i] === 1'b1)
        cnt[i]++;
  end

  alft_link_ctrl #(
    .P_LINK_RSP_CYC     (LNK),
    .P_CONFIRM_WAIT_CYC (CNF),
    .P_APP_RSP_CYC      (APP),
    .P_NODE_RSP_CYC     (NOD),
    .P_INIT_PROC_CYC    (IPR),
    .P_INIT_WAIT_CYC    (IWT)
  ) i_alft_link_ctrl (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .app_rst_line(app_rst_line),
    .baud_sel(baud_sel), .init_done(init_done), .peer_init_done(peer_init_done),
    .link_rx(link_rx), .link_tx_end(link_tx_end), .link_rsp_sent(link_rsp_sent),
    .net_req(net_req), .confirm_enq(confirm_enq), .stopped_ff(stopped_ff),
    .reset_start_ff(reset_start_ff), .baud_div_ff(baud_div_ff), .tx_cmd_ff(tx_cmd_ff),
    .rx_req_take_ff(rx_req_take_ff), .rx_req_drop_ff(rx_req_drop_ff),
    .rsp_pending_ff(rsp_pending_ff), .net_rsp_ff(net_rsp_ff),
    .net_req_drop_ff(net_req_drop_ff), .tmo_ff(tmo_ff), .resend_cnt_ff(resend_cnt_ff)
  );

  alft_appliance_model i_alft_appliance_model (
    .ref_clk(ref_clk), .rst_b(rst_b), .tx_cmd(tx_cmd_ff), .mode(mode),
    .rsp_dly(rsp_dly), .tx_end(link_tx_end), .rsp(m_rsp), .err(m_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] bdiv(input int s);
    int r;
    r = (s < 7) ? rates[s] : 2400;
    return 32'((200000000 + r / 2) / r);
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  // n counts edges after the calling edge; n = 0 sees what that edge launched
  task automatic wait_bit(input int idx, input int lim);
    #1;
    for (n = 0; n <= lim; n++)
    begin
      if (n > 0)
        tick(1);
      if (obs[idx] === 1'b1)
        break;
    end
    if (n > lim)
    begin
      check(32'h0, 32'h1);
      give_verdict();
    end
  endtask

  task automatic pulse(input logic [4:0] sel);
    @(posedge ref_clk);
    {lreq, link_rsp_sent, confirm_enq, init_done, peer_init_done} <= sel;
    @(posedge ref_clk);
    {lreq, link_rsp_sent, confirm_enq, init_done, peer_init_done} <= 5'h00;
  endtask

  task automatic net(input logic g, input logic svc);
    @(posedge ref_clk);
    net_req <= '{valid: 1'b1, is_get: g, is_set: !g, appliance_svc: svc};
    @(posedge ref_clk);
    net_req <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(60));
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(1);
    check(stopped_ff, 32'h1);
    check(baud_div_ff, bdiv(1));
    for (int s = 0; s < 8; s++)
    begin
      @(posedge ref_clk);
      baud_sel <= 3'(s);
      tick(2);
      check(baud_div_ff, bdiv(s));
    end
    @(posedge ref_clk);
    app_rst_line <= 1'b1;
    wait_bit(0, 3);
    check(n, 32'h1);
    check(stopped_ff, 32'h0);
    wait_bit(13, IWT + 8);
    check(n >= IWT && n <= IWT + 4, 32'h1);
    pulse(5'h03);
    for (int g = 0; g < 2; g++)
    begin
      net(g, 1'b0);
      wait_bit(3, 4);
      check(n, 32'h1);
    end
    check(cnt[1], 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      mode    <= (i < 2) ? 2'h0 : 2'(i - 1);
      rsp_dly <= 8'(2 + $urandom % 18);
      k = cnt[7];
      net(i != 1, 1'b1);
      wait_bit(1, 2);
      check(n, 32'h0);
      net(1'b1, 1'b1);
      wait_bit(4, 3);
      check(n, 32'h0);
      if (i == 2)
      begin
        wait_bit(2, 40);
        tick(1);
        check(resend_cnt_ff, 32'h1);
      end
      if (i == 3)
      begin
        wait_bit(2, LNK + 12);
        check(n >= LNK, 32'h1);
        wait_bit(11, NOD);
        @(posedge ref_clk);
        mode <= 2'h0;
      end
      wait_bit(3, 200);
      check(cnt[7] - k, 32'h1);
    end
    @(posedge ref_clk);
    mode <= 2'h2;
    pulse(5'h04);
    wait_bit(1, 2);
    check(tx_cmd_ff.confirm, 32'h1);
    wait_bit(9, CNF + 12);
    check(n >= CNF, 32'h1);
    @(posedge ref_clk);
    mode <= 2'h0;
    wait_bit(7, 200);
    tick(2);
    pulse(5'h10);
    wait_bit(5, 2);
    check(rsp_pending_ff, 32'h1);
    pulse(5'h10);
    wait_bit(6, 2);
    check(n, 32'h0);
    wait_bit(10, APP + 6);
    check(cnt[5], 32'h1);
    pulse(5'h08);
    tick(1);
    check(rsp_pending_ff, 32'h0);
    pulse(5'h10);
    @(posedge ref_clk);
    app_rst_line <= 1'b0;
    tick(2);
    check({stopped_ff, rsp_pending_ff}, 32'h2);
    check(cnt[8] > 0, 32'h1);
    give_verdict();
  end
endmodule
